/* File: src/meas_report_pkg.sv */
// constants shared by the measurement outcome and error reporting block
// assumes a single system clock and a plain address/strobe register port
package meas_report_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_DATA      = 8'h08;
  localparam logic [7:0] OFS_ERR_POP   = 8'h0c;
  localparam logic [7:0] OFS_ERR_COUNT = 8'h10;

  // control field positions and value after reset
  localparam int         CTRL_CONC_BIT    = 0;
  localparam int         CTRL_PANEL_BIT   = 1;
  localparam int         CTRL_RESTART_BIT = 2;
  localparam logic [1:0] CTRL_RESET       = 2'h2;

  // status field positions
  localparam int STAT_MEAS_LSB  = 0;
  localparam int STAT_COMP_LSB  = 4;
  localparam int STAT_ALARM_BIT = 8;
  localparam int STAT_LOCK_BIT  = 9;
  localparam int STAT_KEYEN_BIT = 10;

  // measurement status codes
  localparam logic [1:0] MEAS_NORMAL   = 2'h0;
  localparam logic [1:0] MEAS_OVERLOAD = 2'h1;
  localparam logic [1:0] MEAS_NOCONT   = 2'h2;

  // weighted comparison codes
  localparam logic [3:0] COMP_IN     = 4'h1;
  localparam logic [3:0] COMP_HIGH   = 4'h2;
  localparam logic [3:0] COMP_LOW    = 4'h4;
  localparam logic [3:0] COMP_NOCONT = 4'h8;
  localparam logic [3:0] COMP_RESET  = 4'h0;

  // comparator input encodings from the measurement engine
  localparam logic [1:0] CMP_IN   = 2'h0;
  localparam logic [1:0] CMP_HIGH = 2'h1;
  localparam logic [1:0] CMP_LOW  = 2'h2;

  // 9.9e37 as an ieee single float, returned for overload and no-contact
  localparam logic [31:0] DATA_INVALID = 32'h7e94f575;
  localparam logic [31:0] DATA_RESET   = 32'h00000000;

  // parse limits
  localparam logic [3:0]  HDR_LEN_MAX   = 4'hc;
  localparam logic [15:0] EXP_MAG_MAX   = 16'h7d00;
  localparam logic [8:0]  MANT_DIG_MAX  = 9'h0ff;

  // error source indices, lower index is recorded first
  localparam int ERR_SRCS = 15;
  localparam int SRC_ADC = 0, SRC_LOCK = 1, SRC_OPT = 2, SRC_FUNC = 3;
  localparam int SRC_CMD = 4, SRC_SEP = 5, SRC_GET = 6, SRC_PMORE = 7;
  localparam int SRC_PLESS = 8, SRC_HLONG = 9, SRC_HUNDEF = 10, SRC_EXP = 11;
  localparam int SRC_DIGITS = 12, SRC_SUFFIX = 13, SRC_CHDATA = 14;

  // error codes as 16-bit two's complement
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_ADC      = 16'h000b;
  localparam logic [15:0] ERR_LOCK     = 16'h0015;
  localparam logic [15:0] ERR_OPT      = 16'h001f;
  localparam logic [15:0] ERR_FUNC     = 16'h0020;
  localparam logic [15:0] ERR_CMD      = 16'hff9c;
  localparam logic [15:0] ERR_SEP      = 16'hff99;
  localparam logic [15:0] ERR_GET      = 16'hff97;
  localparam logic [15:0] ERR_PMORE    = 16'hff94;
  localparam logic [15:0] ERR_PLESS    = 16'hff93;
  localparam logic [15:0] ERR_HLONG    = 16'hff90;
  localparam logic [15:0] ERR_HUNDEF   = 16'hff8f;
  localparam logic [15:0] ERR_EXP      = 16'hff85;
  localparam logic [15:0] ERR_DIGITS   = 16'hff84;
  localparam logic [15:0] ERR_SUFFIX   = 16'hff76;
  localparam logic [15:0] ERR_CHDATA   = 16'hff73;
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;

  // default error queue depth
  localparam int ERR_DEPTH = 8;

endpackage : meas_report_pkg

/* File: src/meas_result_error_reporter.sv */
// measurement outcome classification, handler lines, fault and parse error queue
// assumes the parser and measurement engine share CLOCK_I; only the key-lock pin is async
// Summary of operation
// - status code 0 normal, 1 overload, 2 no-contact; invalid results give 9.9e37
// - comparison code weights: 1 in, 2 above upper, 4 below lower, 8 no-contact
// - overload drives both high lines with code 2, or both low lines with code 4
// - no-contact drives its line, status 2, comparison 8, both displays no-contact
// - overload with no-contact reports one outcome only, chosen by the engine's hint
// - converter failure halts measuring, asserts alarm and raises error 11
// - handler key lock blocks panel keys until the pin is released, register writes cannot undo it, key press raises 21
// - concurrent command without the option hardware raises error 31
// - illegal function combination while concurrent enabled raises error 32
// - unmatched syntax fault raises generic error -100
// - illegal character where a separator belongs raises -103
// - group execute trigger inside a program message raises -105
// - more parameters than a header accepts raises -108
// - fewer parameters than a header needs raises -109
// - header mnemonic over twelve characters raises -112
// - well formed but unknown header raises -113
// - exponent magnitude above 32000 raises -123
// - mantissa over 255 digits after leading zeros raises -124
// - suffix after a numeric element that forbids one raises -138
// - bad character data element raises -141
// - full error queue stores -350 in place of the lost error
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module meas_result_error_reporter
  import meas_report_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH
) (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_B_I,
  // register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  // measurement engine results
  input  wire logic        MEAS_DONE_I,
  input  wire logic        OVERLOAD_I,
  input  wire logic        NO_CONTACT_I,
  input  wire logic        OVERLOAD_CONDITION_HIGH_I,
  input  wire logic        NC_WINS_I,
  input  wire logic [1:0]  PRI_CMP_I,
  input  wire logic [1:0]  SEC_CMP_I,
  input  wire logic [31:0] MEAS_DATA_I,
  input  wire logic        ADC_FAIL_I,
  output logic             MEAS_RUN_O,
  // result fields and display codes
  output logic [1:0]       MEAS_STATUS_O,
  output logic [3:0]       COMP_CODE_O,
  output logic [31:0]      DATA_VALUE_O,
  output logic [1:0]       DISP_DATA_O,
  output logic [1:0]       DISP_CMP_O,
  // handler lines, active low
  output logic             PRIMARY_HIGH_LINE_B_O,
  output logic             PRIMARY_IN_LINE_B_O,
  output logic             PRIMARY_LOW_LINE_B_O,
  output logic             SECONDARY_HIGH_LINE_B_O,
  output logic             SECONDARY_IN_LINE_B_O,
  output logic             SECONDARY_LOW_LINE_B_O,
  output logic             NO_CONTACT_LINE_B_O,
  output logic             ALARM_LINE_B_O,
  input  wire logic        KEY_LOCK_B_I,
  // front panel
  input  wire logic        KEY_PRESS_I,
  output logic             KEY_ACCEPT_O,
  output logic             KEYS_ENABLED_O,
  // parser events
  input  wire logic        MSG_ACTIVE_I,
  input  wire logic        GET_I,
  input  wire logic        CONC_CMD_I,
  input  wire logic        OPT_PRESENT_I,
  input  wire logic        FUNC_CMD_I,
  input  wire logic        FUNC_ILLEGAL_I,
  input  wire logic        SYNTAX_ERR_I,
  input  wire logic        SEP_ERR_I,
  input  wire logic        SUFFIX_ERR_I,
  input  wire logic        CHAR_DATA_ERR_I,
  input  wire logic        HDR_CHAR_I,
  input  wire logic        HDR_DONE_I,
  input  wire logic        HDR_KNOWN_I,
  input  wire logic        PARAM_I,
  input  wire logic        UNIT_END_I,
  input  wire logic [3:0]  PARAM_MIN_I,
  input  wire logic [3:0]  PARAM_MAX_I,
  input  wire logic        EXP_DONE_I,
  input  wire logic [15:0] EXP_MAG_I,
  input  wire logic        MANT_DIGIT_I,
  input  wire logic        MANT_ZERO_I,
  input  wire logic        MANT_DONE_I,
  // error queue state
  output logic [3:0]       ERR_COUNT_O
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef logic [DEPTH-1:0][15:0] queue_t;

  typedef struct packed {
    logic                klk1;
    logic                klk2;
    logic                conc_en;
    logic                panel_en;
    logic                alarm;
    logic                key_acc;
    logic [1:0]          meas;
    logic [3:0]          comp;
    logic [31:0]         data;
    logic [1:0]          disp_d;
    logic [1:0]          disp_c;
    logic [6:0]          lines;
    logic [3:0]          hdr_len;
    logic [3:0]          pcnt;
    logic [8:0]          mdig;
    logic                msig;
    logic [ERR_SRCS-1:0] pend;
    queue_t              qmem;
    logic [CW-1:0]       qcnt;
    logic [31:0]         rdata;
  } state_s;

  // handler line index inside lines: pri hi/in/lo, sec hi/in/lo, no-contact
  localparam int LN_PH = 0, LN_PI = 1, LN_PL = 2, LN_SH = 3, LN_SI = 4, LN_SL = 5;
  localparam int LN_NC = 6;

  state_s q;
  state_s d;

  // code of each error source
  function automatic logic [15:0] code_of(input int idx);
    logic [15:0] c;
    c = ERR_NONE;
    unique case (idx)
      SRC_ADC:    c = ERR_ADC;
      SRC_LOCK:   c = ERR_LOCK;
      SRC_OPT:    c = ERR_OPT;
      SRC_FUNC:   c = ERR_FUNC;
      SRC_CMD:    c = ERR_CMD;
      SRC_SEP:    c = ERR_SEP;
      SRC_GET:    c = ERR_GET;
      SRC_PMORE:  c = ERR_PMORE;
      SRC_PLESS:  c = ERR_PLESS;
      SRC_HLONG:  c = ERR_HLONG;
      SRC_HUNDEF: c = ERR_HUNDEF;
      SRC_EXP:    c = ERR_EXP;
      SRC_DIGITS: c = ERR_DIGITS;
      SRC_SUFFIX: c = ERR_SUFFIX;
      default:    c = ERR_CHDATA;
    endcase
    return c;
  endfunction : code_of

  // comparator encoding to weighted comparison code
  function automatic logic [3:0] comp_of(input logic [1:0] cmp);
    logic [3:0] c;
    c = COMP_IN;
    if (cmp == CMP_HIGH) begin
      c = COMP_HIGH;
    end else if (cmp == CMP_LOW) begin
      c = COMP_LOW;
    end
    return c;
  endfunction : comp_of

  logic                locked;
  logic                use_nc;
  logic                use_ov;
  logic                take;
  logic                wr_ctrl;
  logic                pop;
  logic [ERR_SRCS-1:0] raise;
  logic [ERR_SRCS-1:0] clr;
  logic [15:0]         pick;
  logic                pick_vld;
  logic [3:0]          new_len;

  // next state
  always_comb begin
    d = q;
    raise = '0;
    clr = '0;
    pick = ERR_NONE;
    pick_vld = 1'b0;
    new_len = q.hdr_len;

    // two-stage synchroniser on the key-lock pin
    d.klk1 = KEY_LOCK_B_I;
    d.klk2 = q.klk1;
    locked = ~q.klk2;

    // control writes; panel enable is refused while the handler holds the lock
    wr_ctrl = REG_WR_I && (REG_ADDR_I == OFS_CTRL);
    if (wr_ctrl) begin
      d.conc_en = REG_WDATA_I[CTRL_CONC_BIT];
      if (!locked) begin
        d.panel_en = REG_WDATA_I[CTRL_PANEL_BIT];
      end
      if (REG_WDATA_I[CTRL_RESTART_BIT]) begin
        d.alarm = 1'b0;
      end
    end

    // key handling under handler lock
    d.key_acc = KEY_PRESS_I && !locked && q.panel_en;
    raise[SRC_LOCK] = KEY_PRESS_I && locked;

    // converter failure latches alarm and halts result updates
    if (ADC_FAIL_I) begin
      d.alarm = 1'b1;
    end
    raise[SRC_ADC] = ADC_FAIL_I && !q.alarm;

    // classify each finished measurement
    take = MEAS_DONE_I && !q.alarm && !ADC_FAIL_I;
    use_nc = NO_CONTACT_I && (!OVERLOAD_I || NC_WINS_I);
    use_ov = OVERLOAD_I && !use_nc;
    if (take) begin
      d.lines = '0;
      if (use_nc) begin
        d.meas = MEAS_NOCONT;
        d.comp = COMP_NOCONT;
        d.data = DATA_INVALID;
        d.disp_d = MEAS_NOCONT;
        d.disp_c = MEAS_NOCONT;
        d.lines[LN_NC] = 1'b1;
      end else if (use_ov) begin
        d.meas = MEAS_OVERLOAD;
        d.data = DATA_INVALID;
        d.disp_d = MEAS_OVERLOAD;
        if (OVERLOAD_CONDITION_HIGH_I) begin
          d.comp = COMP_HIGH;
          d.disp_c = CMP_HIGH;
          d.lines[LN_PH] = 1'b1;
          d.lines[LN_SH] = 1'b1;
        end else begin
          d.comp = COMP_LOW;
          d.disp_c = CMP_LOW;
          d.lines[LN_PL] = 1'b1;
          d.lines[LN_SL] = 1'b1;
        end
      end else begin
        d.meas = MEAS_NORMAL;
        d.data = MEAS_DATA_I;
        d.comp = comp_of(PRI_CMP_I);
        d.disp_d = MEAS_NORMAL;
        d.disp_c = PRI_CMP_I;
        d.lines[LN_PH] = (PRI_CMP_I == CMP_HIGH);
        d.lines[LN_PL] = (PRI_CMP_I == CMP_LOW);
        d.lines[LN_PI] = (PRI_CMP_I == CMP_IN);
        d.lines[LN_SH] = (SEC_CMP_I == CMP_HIGH);
        d.lines[LN_SL] = (SEC_CMP_I == CMP_LOW);
        d.lines[LN_SI] = (SEC_CMP_I == CMP_IN);
      end
    end

    // option and function checks
    raise[SRC_OPT] = CONC_CMD_I && !OPT_PRESENT_I;
    raise[SRC_FUNC] = FUNC_CMD_I && FUNC_ILLEGAL_I && q.conc_en;

    // flags reported directly by the parser
    raise[SRC_CMD] = SYNTAX_ERR_I;
    raise[SRC_SEP] = SEP_ERR_I;
    raise[SRC_GET] = GET_I && MSG_ACTIVE_I;
    raise[SRC_SUFFIX] = SUFFIX_ERR_I;
    raise[SRC_CHDATA] = CHAR_DATA_ERR_I;

    // header length counter, saturating one past the limit
    if (HDR_CHAR_I && (q.hdr_len <= HDR_LEN_MAX)) begin
      new_len = q.hdr_len + 4'h1;
    end
    d.hdr_len = new_len;
    if (HDR_DONE_I) begin
      d.hdr_len = '0;
      raise[SRC_HLONG] = (new_len > HDR_LEN_MAX);
      raise[SRC_HUNDEF] = (new_len <= HDR_LEN_MAX) && !HDR_KNOWN_I;
    end

    // parameter count against the header's bounds
    if (PARAM_I && (q.pcnt != 4'hf)) begin
      d.pcnt = q.pcnt + 4'h1;
    end
    if (UNIT_END_I) begin
      d.pcnt = '0;
      raise[SRC_PMORE] = (q.pcnt > PARAM_MAX_I);
      raise[SRC_PLESS] = (q.pcnt < PARAM_MIN_I);
    end

    // exponent magnitude check
    raise[SRC_EXP] = EXP_DONE_I && (EXP_MAG_I > EXP_MAG_MAX);

    // mantissa digits, leading zeros not counted
    if (MANT_DIGIT_I && (q.msig || !MANT_ZERO_I)) begin
      d.msig = 1'b1;
      if (q.mdig != 9'h1ff) begin
        d.mdig = q.mdig + 9'h001;
      end
    end
    if (MANT_DONE_I) begin
      d.mdig = '0;
      d.msig = 1'b0;
      raise[SRC_DIGITS] = (q.mdig > MANT_DIG_MAX);
    end

    // pick the lowest pending source, one entry per cycle
    for (int i = ERR_SRCS - 1; i >= 0; i--) begin
      if (q.pend[i]) begin
        pick = code_of(i);
        clr = '0;
        clr[i] = 1'b1;
        pick_vld = 1'b1;
      end
    end
    d.pend = (q.pend & ~clr) | raise;

    // register read; the pop address removes the oldest entry
    pop = REG_RD_I && (REG_ADDR_I == OFS_ERR_POP) && (q.qcnt != '0);
    d.rdata = '0;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        OFS_CTRL: begin
          d.rdata[CTRL_CONC_BIT] = q.conc_en;
          d.rdata[CTRL_PANEL_BIT] = q.panel_en;
        end
        OFS_STATUS: begin
          d.rdata[STAT_MEAS_LSB +: 2] = q.meas;
          d.rdata[STAT_COMP_LSB +: 4] = q.comp;
          d.rdata[STAT_ALARM_BIT] = q.alarm;
          d.rdata[STAT_LOCK_BIT] = locked;
          d.rdata[STAT_KEYEN_BIT] = q.panel_en && !locked;
        end
        OFS_DATA:      d.rdata = q.data;
        OFS_ERR_POP:   d.rdata = {{16{q.qmem[0][15]}}, q.qmem[0]};
        OFS_ERR_COUNT: d.rdata[CW-1:0] = q.qcnt;
        default:       d.rdata = '0;
      endcase
    end

    // queue shift on pop, then append at the tail
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.qmem[i] = q.qmem[i+1];
      end
      d.qmem[DEPTH-1] = ERR_NONE;
      d.qcnt = q.qcnt - CW'(1);
    end
    if (pick_vld) begin
      if (d.qcnt < CW'(DEPTH)) begin
        d.qmem[d.qcnt] = pick;
        d.qcnt = d.qcnt + CW'(1);
      end else begin
        d.qmem[DEPTH-1] = ERR_OVERFLOW;
      end
    end

    if (!RST_B_I) begin
      d = '0;
      d.klk1 = 1'b1;
      d.klk2 = 1'b1;
      d.panel_en = CTRL_RESET[CTRL_PANEL_BIT];
      d.conc_en = CTRL_RESET[CTRL_CONC_BIT];
      d.comp = COMP_RESET;
      d.data = DATA_RESET;
    end
  end

  // state register, synchronous reset applied above
  always_ff @(posedge CLOCK_I) begin
    q <= d;
  end

  // outputs from the state register; handler lines are active low
  assign REG_RDATA_O             = q.rdata;
  assign MEAS_RUN_O              = ~q.alarm;
  assign MEAS_STATUS_O           = q.meas;
  assign COMP_CODE_O             = q.comp;
  assign DATA_VALUE_O            = q.data;
  assign DISP_DATA_O             = q.disp_d;
  assign DISP_CMP_O              = q.disp_c;
  assign PRIMARY_HIGH_LINE_B_O   = ~q.lines[LN_PH];
  assign PRIMARY_IN_LINE_B_O     = ~q.lines[LN_PI];
  assign PRIMARY_LOW_LINE_B_O    = ~q.lines[LN_PL];
  assign SECONDARY_HIGH_LINE_B_O = ~q.lines[LN_SH];
  assign SECONDARY_IN_LINE_B_O   = ~q.lines[LN_SI];
  assign SECONDARY_LOW_LINE_B_O  = ~q.lines[LN_SL];
  assign NO_CONTACT_LINE_B_O     = ~q.lines[LN_NC];
  assign ALARM_LINE_B_O          = ~q.alarm;
  assign KEY_ACCEPT_O            = q.key_acc;
  assign KEYS_ENABLED_O          = q.panel_en & q.klk2;
  assign ERR_COUNT_O             = 4'(q.qcnt);

endmodule : meas_result_error_reporter

/* File: verification/handler_model.sv */
// handler side of the block: drives the key-lock pin on request
// assumes the pin has a pull-up, so a released lock reads high
`timescale 1ns/1ps
module handler_model (
  // lock request from the bench
  input  wire logic lock_i,
  // key-lock pin toward the block, active low
  output logic      key_lock_b_o
);
  // the pull-up wins whenever the handler lets go of the pin
  assign key_lock_b_o = lock_i ? 1'b0 : 1'b1;
endmodule : handler_model

/* File: verification/meas_report_asserts.sv */
// port checker for the measurement reporting block
// assumes one clock domain with synchronous active low reset
`timescale 1ns/1ps
module meas_report_asserts
  import meas_report_pkg::*;
#(
  parameter int DEPTH = ERR_DEPTH
) (
  // clock, reset and register port
  input wire logic        CLOCK_I, RST_B_I, REG_WR_I, REG_RD_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I, MEAS_DATA_I, DATA_VALUE_O,
  // measurement results
  input wire logic        MEAS_DONE_I, OVERLOAD_I, NO_CONTACT_I, OVERLOAD_CONDITION_HIGH_I, NC_WINS_I,
  input wire logic [1:0]  PRI_CMP_I, MEAS_STATUS_O,
  input wire logic [3:0]  COMP_CODE_O, ERR_COUNT_O,
  input wire logic        ADC_FAIL_I, MEAS_RUN_O, ALARM_LINE_B_O, NO_CONTACT_LINE_B_O,
  input wire logic        PRIMARY_HIGH_LINE_B_O, PRIMARY_LOW_LINE_B_O,
  input wire logic        SECONDARY_HIGH_LINE_B_O, SECONDARY_LOW_LINE_B_O,
  // keys and parser
  input wire logic        KEY_LOCK_B_I, KEY_PRESS_I, KEY_ACCEPT_O, KEYS_ENABLED_O, SEP_ERR_I
);
  // accepted measurement and the no-contact winner
  wire acc = MEAS_DONE_I && MEAS_RUN_O && !ADC_FAIL_I;
  wire nc  = NO_CONTACT_I && (!OVERLOAD_I || NC_WINS_I);
  wire rst = REG_WR_I && REG_ADDR_I == OFS_CTRL && REG_WDATA_I[CTRL_RESTART_BIT];

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_nc; acc && nc; endsequence
  sequence s_ov; acc && OVERLOAD_I && !nc; endsequence
  sequence s_lock; !KEY_LOCK_B_I [*6]; endsequence

  nc_outcome_a:
    assert property (s_nc |=> MEAS_STATUS_O == MEAS_NOCONT && COMP_CODE_O == COMP_NOCONT
      && !NO_CONTACT_LINE_B_O && DATA_VALUE_O == DATA_INVALID) else $error("no-contact wrong");
  overload_condition_high_a:
    assert property (s_ov ##0 OVERLOAD_CONDITION_HIGH_I |=> MEAS_STATUS_O == MEAS_OVERLOAD
      && COMP_CODE_O == COMP_HIGH && !PRIMARY_HIGH_LINE_B_O && !SECONDARY_HIGH_LINE_B_O
      && NO_CONTACT_LINE_B_O) else $error("overload high wrong");
  overload_condition_low_a:
    assert property (s_ov ##0 !OVERLOAD_CONDITION_HIGH_I |=> COMP_CODE_O == COMP_LOW
      && !PRIMARY_LOW_LINE_B_O && !SECONDARY_LOW_LINE_B_O && DATA_VALUE_O == DATA_INVALID)
      else $error("overload low wrong");
  normal_data_a:
    assert property (acc && !OVERLOAD_I && !NO_CONTACT_I |=> MEAS_STATUS_O == MEAS_NORMAL
      && DATA_VALUE_O == $past(MEAS_DATA_I) && COMP_CODE_O == (4'h1 << $past(PRI_CMP_I)))
      else $error("normal result wrong");
  adc_alarm_a:
    assert property (ADC_FAIL_I && MEAS_RUN_O |=> !MEAS_RUN_O && !ALARM_LINE_B_O)
      else $error("converter failure not flagged");
  alarm_hold_a:
    assert property (!MEAS_RUN_O && !rst |=> !MEAS_RUN_O && !ALARM_LINE_B_O)
      else $error("alarm dropped early");
  lock_keys_a:
    assert property (s_lock |-> !KEYS_ENABLED_O && !KEY_ACCEPT_O)
      else $error("keys live under lock");
  err_queue_a:
    assert property (SEP_ERR_I && ERR_COUNT_O == 4'h0 && !REG_RD_I ##1 !REG_RD_I
      |=> ERR_COUNT_O != 4'h0) else $error("error not queued");
  depth_bound_a:
    assert property (ERR_COUNT_O <= 4'(DEPTH)) else $error("queue over depth");
endmodule : meas_report_asserts

bind meas_result_error_reporter meas_report_asserts #(.DEPTH(DEPTH)) i_chk (
  .CLOCK_I, .RST_B_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I, .MEAS_DATA_I,
  .DATA_VALUE_O, .MEAS_DONE_I, .OVERLOAD_I, .NO_CONTACT_I, .OVERLOAD_CONDITION_HIGH_I, .NC_WINS_I,
  .PRI_CMP_I, .MEAS_STATUS_O, .COMP_CODE_O, .ERR_COUNT_O, .ADC_FAIL_I, .MEAS_RUN_O,
  .ALARM_LINE_B_O, .NO_CONTACT_LINE_B_O, .PRIMARY_HIGH_LINE_B_O, .PRIMARY_LOW_LINE_B_O,
  .SECONDARY_HIGH_LINE_B_O, .SECONDARY_LOW_LINE_B_O, .KEY_LOCK_B_I, .KEY_PRESS_I,
  .KEY_ACCEPT_O, .KEYS_ENABLED_O, .SEP_ERR_I);

/* File: verification/meas_result_error_reporter_tb.sv */
// self-checking bench: reference model of outcomes and error queue
// assumes a 200 MHz clock and a depth-8 error queue
`timescale 1ns/1ps
module meas_result_error_reporter_tb;
  import meas_report_pkg::*;
  logic CLOCK_I = 1'b0, RST_B_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0, lock = 1'b0;
  logic [7:0] REG_ADDR_I = 8'h00;
  logic [31:0] REG_WDATA_I = 32'h0, MEAS_DATA_I = 32'h0, REG_RDATA_O, DATA_VALUE_O, e_dd;
  logic MEAS_DONE_I = 0, OVERLOAD_I = 0, NO_CONTACT_I = 0, OVERLOAD_CONDITION_HIGH_I = 0, NC_WINS_I = 0;
  logic ADC_FAIL_I = 0, KEY_PRESS_I = 0, MSG_ACTIVE_I = 0, OPT_PRESENT_I = 0;
  logic FUNC_ILLEGAL_I = 1, HDR_KNOWN_I = 1, MANT_ZERO_I = 0, alarm = 0;
  logic KEY_LOCK_B_I, MEAS_RUN_O, ALARM_LINE_B_O, KEY_ACCEPT_O, KEYS_ENABLED_O;
  logic [1:0] PRI_CMP_I = 0, SEC_CMP_I = 0, MEAS_STATUS_O, DISP_DATA_O, DISP_CMP_O, e_st, e_dc;
  logic [3:0] PARAM_MIN_I = 0, PARAM_MAX_I = 2, COMP_CODE_O, ERR_COUNT_O, e_cc;
  logic [15:0] EXP_MAG_I = 16'h0000;
  logic [13:0] ev = 14'h0000; // parser pulses
  wire logic [6:0] ln;        // handler lines, primary high..low, secondary, no-contact
  logic [6:0] e_ln;
  int n_errors = 0, checks = 0, q[$];
  int pos[3] = '{1, 2, 0};

  // clock
  always #2.5 CLOCK_I = ~CLOCK_I;

  handler_model i_hnd (.lock_i(lock), .key_lock_b_o(KEY_LOCK_B_I));
  meas_result_error_reporter #(.DEPTH(8)) i_dut (.CLOCK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I,
    .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .MEAS_DONE_I, .OVERLOAD_I, .NO_CONTACT_I, .OVERLOAD_CONDITION_HIGH_I,
    .NC_WINS_I, .PRI_CMP_I, .SEC_CMP_I, .MEAS_DATA_I, .ADC_FAIL_I, .MEAS_RUN_O, .MEAS_STATUS_O,
    .COMP_CODE_O, .DATA_VALUE_O, .DISP_DATA_O, .DISP_CMP_O, .PRIMARY_HIGH_LINE_B_O(ln[6]),
    .PRIMARY_IN_LINE_B_O(ln[5]), .PRIMARY_LOW_LINE_B_O(ln[4]), .SECONDARY_HIGH_LINE_B_O(ln[3]),
    .SECONDARY_IN_LINE_B_O(ln[2]), .SECONDARY_LOW_LINE_B_O(ln[1]), .NO_CONTACT_LINE_B_O(ln[0]),
    .ALARM_LINE_B_O, .KEY_LOCK_B_I, .KEY_PRESS_I, .KEY_ACCEPT_O, .KEYS_ENABLED_O, .MSG_ACTIVE_I,
    .GET_I(ev[0]), .CONC_CMD_I(ev[1]), .OPT_PRESENT_I, .FUNC_CMD_I(ev[2]), .FUNC_ILLEGAL_I,
    .SYNTAX_ERR_I(ev[3]), .SEP_ERR_I(ev[4]), .SUFFIX_ERR_I(ev[5]), .CHAR_DATA_ERR_I(ev[6]),
    .HDR_CHAR_I(ev[7]), .HDR_DONE_I(ev[8]), .HDR_KNOWN_I, .PARAM_I(ev[9]), .UNIT_END_I(ev[10]),
    .PARAM_MIN_I, .PARAM_MAX_I, .EXP_DONE_I(ev[11]), .EXP_MAG_I, .MANT_DIGIT_I(ev[12]),
    .MANT_ZERO_I, .MANT_DONE_I(ev[13]), .ERR_COUNT_O);

  // verdict and end of run
  task automatic summarize;
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // register write and compared read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    REG_ADDR_I <= a; REG_WDATA_I <= d; REG_WR_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_WR_I <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    REG_ADDR_I <= a; REG_RD_I <= 1'b1;
    @(posedge CLOCK_I);
    REG_RD_I <= 1'b0;
    #1 chk(REG_RDATA_O, e);
  endtask : rdc

  // queue model: a full queue swaps its last entry for the overflow code
  task automatic exp_err(input int c);
    if (q.size() == 8) q[$] = -350;
    else q.push_back(c);
  endtask : exp_err
  task automatic drain;
    repeat (3) @(posedge CLOCK_I);
    rdc(OFS_ERR_COUNT, 32'(q.size()));
    while (q.size() > 0) rdc(OFS_ERR_POP, 32'(q.pop_front()));
    rdc(OFS_ERR_POP, 32'h0);
  endtask : drain

  // n back-to-back pulses on one parser event, then the expected code if any
  task automatic evt(input int b, input int n, input int c);
    repeat (n) begin
      @(posedge CLOCK_I);
      ev <= 14'(1) << b;
    end
    @(posedge CLOCK_I);
    ev <= '0;
    if (c != 0) exp_err(c);
    repeat (2) @(posedge CLOCK_I);
  endtask : evt

  // one measurement against the outcome model; refused while alarmed
  task automatic meas(input logic ov, nc, hi, win, input logic [1:0] p, s);
    logic [31:0] d;
    d = $urandom;
    @(posedge CLOCK_I);
    {OVERLOAD_I, NO_CONTACT_I, OVERLOAD_CONDITION_HIGH_I, NC_WINS_I} <= {ov, nc, hi, win};
    {PRI_CMP_I, SEC_CMP_I, MEAS_DATA_I, MEAS_DONE_I} <= {p, s, d, 1'b1};
    @(posedge CLOCK_I);
    MEAS_DONE_I <= 1'b0;
    if (!alarm && nc && (!ov || win)) {e_st, e_cc, e_dd, e_ln, e_dc} = {2'h2, 4'h8,
      DATA_INVALID, 7'h01, 2'h2};
    else if (!alarm && ov) {e_st, e_cc, e_dd, e_ln, e_dc} = {2'h1, hi ? 4'h2 : 4'h4,
      DATA_INVALID, hi ? 7'h48 : 7'h12, hi ? 2'h1 : 2'h2};
    else if (!alarm) {e_st, e_cc, e_dd, e_ln, e_dc} = {2'h0, 4'h1 << p, d,
      7'((1 << (4 + pos[p])) | (1 << (1 + pos[s]))), p};
    #1 chk(32'({MEAS_STATUS_O, DISP_DATA_O, DISP_CMP_O, COMP_CODE_O, ~ln}),
      32'({e_st, e_st, e_dc, e_cc, e_ln}));
    chk(DATA_VALUE_O, e_dd);
  endtask : meas

  // hang guard
  initial begin
    repeat (100000) @(posedge CLOCK_I);
    n_errors++;
    summarize();
  end

  // main sequence
  initial begin
    void'($urandom(54053));
    repeat (4) @(posedge CLOCK_I);
    RST_B_I <= 1'b1;
    rdc(OFS_CTRL, 32'h2);
    rdc(8'h14, 32'h0);
    repeat (40) meas(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
      2'($urandom % 3), 2'($urandom % 3));
    // last outcome as software sees it: keys enabled, no alarm, no lock
    rdc(OFS_STATUS, {21'h0, 1'b1, 2'h0, e_cc, 2'h0, e_st});
    rdc(OFS_DATA, e_dd);
    // converter failure: halts, alarms, refuses, restarts
    @(posedge CLOCK_I) ADC_FAIL_I <= 1'b1;
    @(posedge CLOCK_I) ADC_FAIL_I <= 1'b0;
    alarm = 1'b1;
    exp_err(11);
    #1 chk(32'({MEAS_RUN_O, ALARM_LINE_B_O}), 32'h0);
    meas(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0);
    @(posedge CLOCK_I) ADC_FAIL_I <= 1'b1;
    @(posedge CLOCK_I) ADC_FAIL_I <= 1'b0;
    drain();
    wr(OFS_CTRL, 32'h6);
    alarm = 1'b0;
    #1 chk(32'({MEAS_RUN_O, ALARM_LINE_B_O}), 32'h3);
    // key lock: press refused, message raised, panel enable cannot be cleared while locked
    @(posedge CLOCK_I) KEY_PRESS_I <= 1'b1;
    @(posedge CLOCK_I) KEY_PRESS_I <= 1'b0;
    #1 chk(32'(KEY_ACCEPT_O), 32'h1);
    lock <= 1'b1;
    repeat (5) @(posedge CLOCK_I);
    wr(OFS_CTRL, 32'h0);
    @(posedge CLOCK_I) KEY_PRESS_I <= 1'b1;
    @(posedge CLOCK_I) KEY_PRESS_I <= 1'b0;
    exp_err(21);
    #1 chk(32'({KEY_ACCEPT_O, KEYS_ENABLED_O}), 32'h0);
    lock <= 1'b0;
    repeat (5) @(posedge CLOCK_I);
    #1 chk(32'(KEYS_ENABLED_O), 32'h1);
    wr(OFS_CTRL, 32'h2);
    drain();
    // program message faults with boundary values that must stay silent
    MSG_ACTIVE_I <= 1'b1;
    evt(1, 1, 31);
    evt(2, 1, 0);
    wr(OFS_CTRL, 32'h3);
    evt(2, 1, 32);
    evt(3, 1, -100);
    evt(4, 1, -103);
    evt(0, 1, -105);
    evt(9, 3, 0);
    evt(10, 1, -108);
    PARAM_MIN_I <= 4'h1;
    evt(10, 1, -109);
    evt(9, 2, 0);
    evt(10, 1, 0);
    drain();
    evt(7, 12, 0);
    evt(8, 1, 0);
    evt(7, 13, 0);
    evt(8, 1, -112);
    HDR_KNOWN_I <= 1'b0;
    evt(7, 12, 0);
    evt(8, 1, -113);
    EXP_MAG_I <= 16'h7d00;
    evt(11, 1, 0);
    EXP_MAG_I <= 16'h7d01;
    evt(11, 1, -123);
    MANT_ZERO_I <= 1'b1;
    evt(12, 3, 0);
    MANT_ZERO_I <= 1'b0;
    evt(12, 255, 0);
    evt(13, 1, 0);
    evt(12, 256, 0);
    evt(13, 1, -124);
    evt(5, 1, -138);
    evt(6, 1, -141);
    drain();
    MSG_ACTIVE_I <= 1'b0;
    evt(0, 1, 0);
    repeat (9) evt(4, 1, -103);
    drain();
    summarize();
  end
endmodule : meas_result_error_reporter_tb
